/* File: rpc_pkg.sv */
package rpc_pkg;

  // ----------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [9:0]  IF_BW_AND_MODULATION_SELECT_IDX = 10'h115;
  localparam logic [9:0]  AFC_MODE_CONFIG_IDX             = 10'h116;
  localparam logic [9:0]  AFC_LOOP_GAINS_IDX              = 10'h117;
  localparam logic [9:0]  IQ_PHASE_TRIM_IDX               = 10'h118;
  localparam logic [9:0]  IQ_GAIN_TRIM_IDX                = 10'h119;
  localparam logic [9:0]  PREAMBLE_ERROR_TOLERANCE_IDX    = 10'h11b;
  localparam logic [9:0]  SYMBOL_CODING_OPTIONS_IDX       = 10'h11c;
  localparam logic [9:0]  PREAMBLE_BYTE_COUNT_IDX         = 10'h11d;
  localparam logic [9:0]  CRC_POLYNOMIAL_LOW_IDX          = 10'h11e;
  localparam logic [9:0]  CRC_POLYNOMIAL_HIGH_IDX         = 10'h11f;
  localparam logic [11:0] IF_BW_AND_MODULATION_SELECT_OFS =
    {IF_BW_AND_MODULATION_SELECT_IDX, 2'h0};
  localparam logic [11:0] AFC_MODE_CONFIG_OFS             =
    {AFC_MODE_CONFIG_IDX, 2'h0};
  localparam logic [11:0] AFC_LOOP_GAINS_OFS              =
    {AFC_LOOP_GAINS_IDX, 2'h0};
  localparam logic [11:0] IQ_PHASE_TRIM_OFS               =
    {IQ_PHASE_TRIM_IDX, 2'h0};
  localparam logic [11:0] IQ_GAIN_TRIM_OFS                =
    {IQ_GAIN_TRIM_IDX, 2'h0};
  localparam logic [11:0] PREAMBLE_ERROR_TOLERANCE_OFS    =
    {PREAMBLE_ERROR_TOLERANCE_IDX, 2'h0};
  localparam logic [11:0] SYMBOL_CODING_OPTIONS_OFS       =
    {SYMBOL_CODING_OPTIONS_IDX, 2'h0};
  localparam logic [11:0] PREAMBLE_BYTE_COUNT_OFS         =
    {PREAMBLE_BYTE_COUNT_IDX, 2'h0};
  localparam logic [11:0] CRC_POLYNOMIAL_LOW_OFS          =
    {CRC_POLYNOMIAL_LOW_IDX, 2'h0};
  localparam logic [11:0] CRC_POLYNOMIAL_HIGH_OFS         =
    {CRC_POLYNOMIAL_HIGH_IDX, 2'h0};

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] IF_BW_AND_MODULATION_SELECT_RST = 8'h00;
  localparam logic [7:0] AFC_MODE_CONFIG_RST             = 8'h08;
  localparam logic [7:0] AFC_LOOP_GAINS_RST              = 8'h37;
  localparam logic [7:0] IQ_PHASE_TRIM_RST               = 8'h00;
  localparam logic [7:0] IQ_GAIN_TRIM_RST                = 8'h00;
  localparam logic [7:0] PREAMBLE_ERROR_TOLERANCE_RST    = 8'h0c;
  localparam logic [7:0] SYMBOL_CODING_OPTIONS_RST       = 8'h00;
  localparam logic [7:0] PREAMBLE_BYTE_COUNT_RST         = 8'h00;
  localparam logic [7:0] CRC_POLYNOMIAL_LOW_RST          = 8'h00;
  localparam logic [7:0] CRC_POLYNOMIAL_HIGH_RST         = 8'h00;

  // ----------------------------------------------------------------
  // Field positions and codes
  // ----------------------------------------------------------------
  localparam int FILT_BW_MSB    = 7;
  localparam int FILT_BW_LSB    = 6;
  localparam int TXMOD_MSB      = 5;
  localparam int TXMOD_LSB      = 3;
  localparam int RXDEM_MSB      = 2;
  localparam int RXDEM_LSB      = 0;
  localparam int FC_MODE_MSB    = 1;
  localparam int FC_MODE_LSB    = 0;
  localparam int KP_MSB         = 7;
  localparam int KP_LSB         = 4;
  localparam int KI_MSB         = 3;
  localparam int KI_LSB         = 0;
  localparam int TRIM_MSB       = 6;
  localparam int TOL_MSB        = 3;
  localparam int BIPHASE_BIT    = 6;
  localparam int CUSTOM_CRC_BIT = 5;
  localparam int WHITEN_BIT     = 3;

  localparam logic [1:0] FILT_BW_300K   = 2'h3;
  localparam logic [2:0] TXMOD_FSK      = 3'h0;
  localparam logic [2:0] TXMOD_GFSK     = 3'h1;
  localparam logic [2:0] TXMOD_CARRIER  = 3'h3;
  localparam logic [2:0] RXDEM_FSK      = 3'h0;
  localparam logic [1:0] FC_FREE        = 2'h0;
  localparam logic [1:0] FC_OFF         = 2'h1;
  localparam logic [1:0] FC_HOLD        = 2'h2;
  localparam logic [1:0] FC_LOCK        = 2'h3;
  localparam logic [3:0] TOL_DISABLED   = 4'h0;
  localparam logic [3:0] TOL_MIN_OK     = 4'h8;
  localparam logic [3:0] TOL_EXACT      = 4'hc;

  // Intermediate frequency in kHz
  localparam logic [8:0] IF_KHZ_NORMAL  = 9'h0c8;
  localparam logic [8:0] IF_KHZ_WIDE    = 9'h12c;

  typedef enum logic [1:0] {
    RPC_TX_FSK,
    RPC_TX_GFSK,
    RPC_TX_CARRIER,
    RPC_TX_RSVD
  } rpc_tx_mode_t;

endpackage

/* File: rpc_if.sv */
`timescale 1ns/100ps
interface rpc_if;
  logic        wr;
  logic [11:0] addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        hit;

  modport bus (output wr, output addr, output wdata,
               input rdata, input hit);
  modport regs (input wr, input addr, input wdata,
                output rdata, output hit);
endinterface

/* File: rpc_regfile.sv */
`timescale 1ns/100ps
module rpc_regfile (
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  // Access port
  rpc_if.regs              acc,
  // Stored bytes
  output logic [7:0]       o_cfg [0:9]
);

  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS [0:9] = '{
    rpc_pkg::IF_BW_AND_MODULATION_SELECT_OFS,
    rpc_pkg::AFC_MODE_CONFIG_OFS,
    rpc_pkg::AFC_LOOP_GAINS_OFS,
    rpc_pkg::IQ_PHASE_TRIM_OFS,
    rpc_pkg::IQ_GAIN_TRIM_OFS,
    rpc_pkg::PREAMBLE_ERROR_TOLERANCE_OFS,
    rpc_pkg::SYMBOL_CODING_OPTIONS_OFS,
    rpc_pkg::PREAMBLE_BYTE_COUNT_OFS,
    rpc_pkg::CRC_POLYNOMIAL_LOW_OFS,
    rpc_pkg::CRC_POLYNOMIAL_HIGH_OFS};
  localparam logic [7:0] RST [0:9] = '{
    rpc_pkg::IF_BW_AND_MODULATION_SELECT_RST,
    rpc_pkg::AFC_MODE_CONFIG_RST,
    rpc_pkg::AFC_LOOP_GAINS_RST,
    rpc_pkg::IQ_PHASE_TRIM_RST,
    rpc_pkg::IQ_GAIN_TRIM_RST,
    rpc_pkg::PREAMBLE_ERROR_TOLERANCE_RST,
    rpc_pkg::SYMBOL_CODING_OPTIONS_RST,
    rpc_pkg::PREAMBLE_BYTE_COUNT_RST,
    rpc_pkg::CRC_POLYNOMIAL_LOW_RST,
    rpc_pkg::CRC_POLYNOMIAL_HIGH_RST};

  always_comb begin
    acc.hit   = 1'b0;
    acc.rdata = 8'h00;
    for (int k = 0; k < 10; k++) begin
      if (acc.addr == OFS[k]) begin
        acc.hit   = 1'b1;
        acc.rdata = o_cfg[k];
      end
    end
  end

  // Plain storage, no side effects
  for (genvar g = 0; g < 10; g++) begin : g_reg
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        o_cfg[g] <= RST[g];
      end else if (acc.wr && acc.addr == OFS[g]) begin
        o_cfg[g] <= acc.wdata; // [RULE18]
      end
    end
  end

endmodule // rpc_regfile

/* File: rpc_top.sv */
`timescale 1ns/100ps
// How it works
// (RULE1) 300 kHz bandwidth moves IF to 300
// (RULE2) Tx modulation: FSK, GFSK, carrier
// (RULE3) Rx demodulation: only code 000 valid
// (RULE4) AFC free, disabled, or held
// (RULE5) AFC lock; sync lock needs tolerance zero
// (RULE6) Upper nibble is proportional gain
// (RULE7) Lower nibble is integral gain
// (RULE8) Seven-bit I/Q phase trim, bit7 zero
// (RULE9) Seven-bit I/Q gain trim, bit7 zero
// (RULE10) Preamble tolerance codes 0, 8..12 meaningful
// (RULE11) Bit 6 enables Manchester coding
// (RULE12) Bit 5 selects programmable CRC
// (RULE13) Bit 3 enables whitening
// (RULE14) Preamble bits equal eight times bytes
// (RULE15) Low byte holds polynomial bits 7..0
// (RULE16) Next register holds polynomial bits 15..8
// (RULE17) Software writes reserved bits as zero
// (RULE18) Plain read/write bytes, no side effects
module rpc_top (
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic [3:0]  i_pstrb,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Filter and IF
  output logic [1:0]       o_if_filter_bandwidth,
  output logic [8:0]       o_if_freq_khz,
  // Modulation
  output logic [2:0]       o_tx_modulation_select,
  output logic             o_tx_mod_gaussian,
  output logic             o_tx_carrier_only,
  output logic [2:0]       o_rx_demodulation_select,
  output logic             o_cfg_reserved_code,
  // Frequency correction
  output logic             o_freq_corr_polarity,
  output logic [1:0]       o_freq_corr_algorithm,
  output logic [1:0]       o_freq_corr_mode,
  output logic             o_freq_corr_run,
  output logic             o_freq_corr_freeze,
  output logic             o_freq_corr_lock_on_preamble,
  output logic             o_freq_corr_lock_on_sync,
  output logic [3:0]       o_freq_corr_prop_gain,
  output logic [3:0]       o_freq_corr_int_gain,
  // Image rejection
  output logic [6:0]       o_iq_phase_correction,
  output logic [6:0]       o_iq_gain_correction,
  // Preamble
  output logic             o_preamble_detect_en,
  output logic [3:0]       o_preamble_err_pairs,
  output logic [7:0]       o_preamble_byte_count,
  output logic [10:0]      o_preamble_bits,
  // Symbol coding
  output logic             o_biphase_coding_enable,
  output logic             o_custom_checksum_select,
  output logic             o_whitening_enable,
  output logic [15:0]      o_checksum_polynomial
);

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  rpc_if      acc ();
  logic [7:0] cfg [0:9];

  // Zero wait states; byte 0 lane carries the register
  assign o_pready     = 1'b1;
  assign acc.addr     = i_paddr;
  assign acc.wdata    = i_pwdata[7:0];
  assign acc.wr       = i_psel && i_penable && i_pwrite && i_pstrb[0]
                        && acc.hit;

  always_comb begin
    o_pslverr = i_psel && i_penable && !acc.hit;
  end

  logic [31:0] prdata_r;
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prdata_r <= 32'h0000_0000;
    end else if (i_psel && !i_penable && !i_pwrite) begin
      prdata_r <= {24'h00_0000, acc.rdata}; // [RULE18]
    end
  end
  assign o_prdata = prdata_r;

  rpc_regfile u_regs (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .acc     (acc),
    .o_cfg   (cfg)
  );

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic tol_valid(input logic [3:0] t);
    return (t == rpc_pkg::TOL_DISABLED) ||
           (t >= rpc_pkg::TOL_MIN_OK && t <= rpc_pkg::TOL_EXACT);
  endfunction

  logic [7:0] r_mod;
  logic [7:0] r_afc;
  logic [7:0] r_gain;
  logic [7:0] r_tol;
  logic [7:0] r_sym;
  assign r_mod  = cfg[0];
  assign r_afc  = cfg[1];
  assign r_gain = cfg[2];
  assign r_tol  = cfg[5];
  assign r_sym  = cfg[6];

  // ----------------------------------------------------------------
  // Registered configuration outputs
  // ----------------------------------------------------------------
  logic [3:0] tol;
  logic [1:0] fmode;
  logic [1:0] fbw;
  assign tol   = r_tol[rpc_pkg::TOL_MSB:0];
  assign fmode = r_afc[rpc_pkg::FC_MODE_MSB:rpc_pkg::FC_MODE_LSB];
  assign fbw   = r_mod[rpc_pkg::FILT_BW_MSB:rpc_pkg::FILT_BW_LSB];

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_if_filter_bandwidth <= 2'h0;
      o_if_freq_khz         <= rpc_pkg::IF_KHZ_NORMAL;
    end else begin
      o_if_filter_bandwidth <= fbw;
      o_if_freq_khz <= (fbw == rpc_pkg::FILT_BW_300K) ?
                       rpc_pkg::IF_KHZ_WIDE :
                       rpc_pkg::IF_KHZ_NORMAL; // [RULE1]
    end
  end

  logic [2:0] txm;
  logic [2:0] rxd;
  assign txm = r_mod[rpc_pkg::TXMOD_MSB:rpc_pkg::TXMOD_LSB];
  assign rxd = r_mod[rpc_pkg::RXDEM_MSB:rpc_pkg::RXDEM_LSB];

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_tx_modulation_select   <= rpc_pkg::TXMOD_FSK;
      o_tx_mod_gaussian        <= 1'b0;
      o_tx_carrier_only        <= 1'b0;
      o_rx_demodulation_select <= rpc_pkg::RXDEM_FSK;
      o_cfg_reserved_code      <= 1'b0;
    end else begin
      o_tx_modulation_select   <= txm;
      o_tx_mod_gaussian        <= (txm == rpc_pkg::TXMOD_GFSK); // [RULE2]
      o_tx_carrier_only        <= (txm == rpc_pkg::TXMOD_CARRIER); // [RULE2]
      o_rx_demodulation_select <= rxd;
      // Flags unusable codes; the select outputs still carry the raw codes
      o_cfg_reserved_code <= (txm != rpc_pkg::TXMOD_FSK &&
                              txm != rpc_pkg::TXMOD_GFSK &&
                              txm != rpc_pkg::TXMOD_CARRIER) || // [RULE2]
                             (rxd != rpc_pkg::RXDEM_FSK) || // [RULE3]
                             !tol_valid(tol); // [RULE10]
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_freq_corr_polarity         <= 1'b0;
      o_freq_corr_algorithm        <= 2'h2;
      o_freq_corr_mode             <= rpc_pkg::FC_FREE;
      o_freq_corr_run              <= 1'b1;
      o_freq_corr_freeze           <= 1'b0;
      o_freq_corr_lock_on_preamble <= 1'b0;
      o_freq_corr_lock_on_sync     <= 1'b0;
    end else begin
      // Polarity and algorithm passed through as written [RULE17]
      o_freq_corr_polarity  <= r_afc[4];
      o_freq_corr_algorithm <= r_afc[3:2];
      o_freq_corr_mode      <= fmode;
      o_freq_corr_run       <= (fmode != rpc_pkg::FC_OFF); // [RULE4]
      o_freq_corr_freeze    <= (fmode == rpc_pkg::FC_HOLD); // [RULE4]
      o_freq_corr_lock_on_preamble <= (fmode == rpc_pkg::FC_LOCK) &&
                                      (tol != rpc_pkg::TOL_DISABLED);
      o_freq_corr_lock_on_sync <= (fmode == rpc_pkg::FC_LOCK) &&
                                  (tol == rpc_pkg::TOL_DISABLED); // [RULE5]
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_freq_corr_prop_gain <= 4'h3;
      o_freq_corr_int_gain  <= 4'h7;
      o_iq_phase_correction <= 7'h00;
      o_iq_gain_correction  <= 7'h00;
    end else begin
      o_freq_corr_prop_gain <=
        r_gain[rpc_pkg::KP_MSB:rpc_pkg::KP_LSB]; // [RULE6]
      o_freq_corr_int_gain  <=
        r_gain[rpc_pkg::KI_MSB:rpc_pkg::KI_LSB]; // [RULE7]
      o_iq_phase_correction <= cfg[3][rpc_pkg::TRIM_MSB:0]; // [RULE8]
      o_iq_gain_correction  <= cfg[4][rpc_pkg::TRIM_MSB:0]; // [RULE9]
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_preamble_detect_en  <= 1'b1;
      o_preamble_err_pairs  <= 4'h0;
      o_preamble_byte_count <= 8'h00;
      o_preamble_bits       <= 11'h000;
    end else begin
      o_preamble_detect_en  <= (tol != rpc_pkg::TOL_DISABLED); // [RULE10]
      // Allowed bad pairs out of 12; zero when not in 8..12
      o_preamble_err_pairs  <= (tol >= rpc_pkg::TOL_MIN_OK &&
                                tol <= rpc_pkg::TOL_EXACT) ?
                               4'(rpc_pkg::TOL_EXACT - tol) :
                               4'h0; // [RULE10]
      o_preamble_byte_count <= cfg[7];
      o_preamble_bits       <= {cfg[7], 3'h0}; // [RULE14]
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_biphase_coding_enable  <= 1'b0;
      o_custom_checksum_select <= 1'b0;
      o_whitening_enable       <= 1'b0;
      o_checksum_polynomial    <= 16'h0000;
    end else begin
      o_biphase_coding_enable  <= r_sym[rpc_pkg::BIPHASE_BIT]; // [RULE11]
      o_custom_checksum_select <= r_sym[rpc_pkg::CUSTOM_CRC_BIT]; // [RULE12]
      o_whitening_enable       <= r_sym[rpc_pkg::WHITEN_BIT]; // [RULE13]
      o_checksum_polynomial    <= {cfg[9], cfg[8]}; // [RULE15] [RULE16]
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_if_shift;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (fbw == rpc_pkg::FILT_BW_300K) |=> (o_if_freq_khz == 9'h12c);
  endproperty
  a_if_shift: assert property (p_if_shift) // [RULE1]
    else $error("IF not moved for widest filter");

  property p_carrier;
    @(posedge i_mclk) disable iff (!i_rst_n)
    o_tx_carrier_only |-> o_tx_modulation_select == 3'h3 &&
                          !o_tx_mod_gaussian;
  endproperty
  a_carrier: assert property (p_carrier) // [RULE2]
    else $error("Carrier flag inconsistent");

  property p_rxd;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (o_rx_demodulation_select != 3'h0) |-> o_cfg_reserved_code;
  endproperty
  a_rxd: assert property (p_rxd) // [RULE3]
    else $error("Reserved demod code not flagged");

  property p_fc_off;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (fmode == rpc_pkg::FC_OFF) |=> !o_freq_corr_run && !o_freq_corr_freeze;
  endproperty
  a_fc_off: assert property (p_fc_off) // [RULE4]
    else $error("AFC not disabled");

  property p_lock_sync;
    @(posedge i_mclk) disable iff (!i_rst_n)
    o_freq_corr_lock_on_sync |-> o_freq_corr_mode == rpc_pkg::FC_LOCK &&
                                 !o_preamble_detect_en;
  endproperty
  a_lock_sync: assert property (p_lock_sync) // [RULE5]
    else $error("Sync lock with preamble detection on");

  property p_gains;
    @(posedge i_mclk) disable iff (!i_rst_n)
    $changed(r_gain) |=> {o_freq_corr_prop_gain, o_freq_corr_int_gain}
                         == $past(r_gain);
  endproperty
  a_gains: assert property (p_gains) // [RULE6] [RULE7]
    else $error("PI gains not following register");

  property p_pairs;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (tol == 4'h9) |=> (o_preamble_err_pairs == 4'h3);
  endproperty
  a_pairs: assert property (p_pairs) // [RULE10]
    else $error("Wrong preamble error pairs");

  property p_pbits;
    @(posedge i_mclk) disable iff (!i_rst_n)
    o_preamble_bits == 11'(o_preamble_byte_count) * 11'h008;
  endproperty
  a_pbits: assert property (p_pbits) // [RULE14]
    else $error("Preamble bits not eight per byte");

  property p_rdback;
    @(posedge i_mclk) disable iff (!i_rst_n)
    acc.wr && acc.addr == rpc_pkg::SYMBOL_CODING_OPTIONS_OFS |=>
      r_sym == $past(i_pwdata[7:0]) ##2
      o_whitening_enable == r_sym[3];
  endproperty
  a_rdback: assert property (p_rdback) // [RULE18] [RULE13]
    else $error("Write not stored or not applied");

  property p_rd_upper;
    @(posedge i_mclk) disable iff (!i_rst_n)
    o_prdata[31:8] == 24'h00_0000;
  endproperty
  a_rd_upper: assert property (p_rd_upper) // [RULE18]
    else $error("Read data upper bytes not zero");

  property p_gain_wr;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (i_psel && i_penable && i_pwrite && i_pstrb[0] &&
     i_paddr == rpc_pkg::AFC_LOOP_GAINS_OFS) |=>
      r_gain == $past(i_pwdata[7:0]);
  endproperty
  a_gain_wr: assert property (p_gain_wr) // [RULE18]
    else $error("Gain byte write not stored");

  property p_no_strobe;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (i_psel && i_penable && i_pwrite && !i_pstrb[0] &&
     i_paddr == rpc_pkg::PREAMBLE_BYTE_COUNT_OFS) |=> $stable(cfg[7]);
  endproperty
  a_no_strobe: assert property (p_no_strobe) // [RULE18]
    else $error("Unstrobed write changed a register");

  property p_lock_pre;
    @(posedge i_mclk) disable iff (!i_rst_n)
    o_freq_corr_lock_on_preamble |-> o_preamble_detect_en &&
                                     o_freq_corr_run;
  endproperty
  a_lock_pre: assert property (p_lock_pre) // [RULE5]
    else $error("Preamble lock without detection");

  c_lock: cover property (@(posedge i_mclk) o_freq_corr_lock_on_sync);
  c_wide: cover property (@(posedge i_mclk) o_if_freq_khz == 9'h12c);
  c_man:  cover property (@(posedge i_mclk) o_biphase_coding_enable);
  c_err:  cover property (@(posedge i_mclk) o_pslverr);
  c_pre:  cover property (@(posedge i_mclk) o_freq_corr_lock_on_preamble);

endmodule // rpc_top

/* File: tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  // ----------------------------------------------------------------
  // Clock, reset and bus signals
  // ----------------------------------------------------------------
  logic        i_mclk = 1'b0;
  logic        i_rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [1:0]  filt_bw;
  logic [8:0]  if_khz;
  logic [2:0]  txm;
  logic        gauss;
  logic        carrier;
  logic [2:0]  rxd;
  logic        rsvd;
  logic        fc_pol;
  logic [1:0]  fc_alg;
  logic [1:0]  fc_mode;
  logic        fc_run;
  logic        fc_frz;
  logic        fc_lkp;
  logic        fc_lks;
  logic [3:0]  kp;
  logic [3:0]  ki;
  logic [6:0]  iq_ph;
  logic [6:0]  iq_gn;
  logic        pre_en;
  logic [3:0]  pre_pairs;
  logic [7:0]  pre_cnt;
  logic [10:0] pre_bits;
  logic        bip;
  logic        ccrc;
  logic        whit;
  logic [15:0] poly;
  int          errors;
  int          comparisons;
  int          cycles = 0;
  logic [31:0] lfsr;
  logic [7:0]  exp_reg [0:9];

  rpc_top dut (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr),
    .o_if_filter_bandwidth(filt_bw), .o_if_freq_khz(if_khz),
    .o_tx_modulation_select(txm), .o_tx_mod_gaussian(gauss),
    .o_tx_carrier_only(carrier), .o_rx_demodulation_select(rxd),
    .o_cfg_reserved_code(rsvd), .o_freq_corr_polarity(fc_pol),
    .o_freq_corr_algorithm(fc_alg), .o_freq_corr_mode(fc_mode),
    .o_freq_corr_run(fc_run), .o_freq_corr_freeze(fc_frz),
    .o_freq_corr_lock_on_preamble(fc_lkp),
    .o_freq_corr_lock_on_sync(fc_lks), .o_freq_corr_prop_gain(kp),
    .o_freq_corr_int_gain(ki), .o_iq_phase_correction(iq_ph),
    .o_iq_gain_correction(iq_gn), .o_preamble_detect_en(pre_en),
    .o_preamble_err_pairs(pre_pairs), .o_preamble_byte_count(pre_cnt),
    .o_preamble_bits(pre_bits), .o_biphase_coding_enable(bip),
    .o_custom_checksum_select(ccrc), .o_whitening_enable(whit),
    .o_checksum_polynomial(poly)
  );

  always #10 i_mclk = ~i_mclk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    lfsr_next = {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h0);
  endfunction

  function automatic logic [11:0] addr_of(input int i);
    case (i)
      0: addr_of = rpc_pkg::IF_BW_AND_MODULATION_SELECT_OFS;
      1: addr_of = rpc_pkg::AFC_MODE_CONFIG_OFS;
      2: addr_of = rpc_pkg::AFC_LOOP_GAINS_OFS;
      3: addr_of = rpc_pkg::IQ_PHASE_TRIM_OFS;
      4: addr_of = rpc_pkg::IQ_GAIN_TRIM_OFS;
      5: addr_of = rpc_pkg::PREAMBLE_ERROR_TOLERANCE_OFS;
      6: addr_of = rpc_pkg::SYMBOL_CODING_OPTIONS_OFS;
      7: addr_of = rpc_pkg::PREAMBLE_BYTE_COUNT_OFS;
      8: addr_of = rpc_pkg::CRC_POLYNOMIAL_LOW_OFS;
      default: addr_of = rpc_pkg::CRC_POLYNOMIAL_HIGH_OFS;
    endcase
  endfunction

  // Software keeps reserved bits zero and fixed AFC fields as set
  function automatic logic [7:0] legal(input int i, input logic [7:0] v);
    case (i)
      1: legal = {6'h02, v[1:0]};
      3, 4: legal = v & 8'h7f;
      5: legal = v & 8'h0f;
      6: legal = v & 8'h68;
      default: legal = v;
    endcase
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge i_mclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      errors++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // Bus master
  // ----------------------------------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [7:0] d, input logic [3:0] st,
                     output logic [31:0] rd, output logic err);
    @(posedge i_mclk);
    lfsr = lfsr_next(lfsr);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {lfsr[23:0], d};
    pstrb   <= st;
    @(posedge i_mclk);
    penable <= 1'b1;
    do @(posedge i_mclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic check_outputs();
    logic [7:0] r0;
    logic [2:0] tx;
    logic [3:0] tol;
    logic [1:0] m;
    logic       ok;
    r0 = exp_reg[0];
    tx = r0[5:3];
    tol = exp_reg[5][3:0];
    m = exp_reg[1][1:0];
    ok = (tol == 4'h0) || (tol >= 4'h8 && tol <= 4'hc);
    check({filt_bw, if_khz}, {r0[7:6],
          (r0[7:6] == 2'h3) ? 9'h12c : 9'h0c8});
    check({txm, gauss, carrier, rxd, rsvd}, {tx, tx == 3'h1, tx == 3'h3,
          r0[2:0], !(tx == 3'h0 || tx == 3'h1 || tx == 3'h3) ||
          r0[2:0] != 3'h0 || !ok});
    check({fc_pol, fc_alg, fc_mode, fc_run, fc_frz, fc_lkp, fc_lks},
          {exp_reg[1][4:0], m != 2'h1, m == 2'h2, m == 2'h3 && tol != 0,
           m == 2'h3 && tol == 0});
    check({kp, ki}, exp_reg[2]);
    check(iq_ph, exp_reg[3][6:0]);
    check(iq_gn, exp_reg[4][6:0]);
    check({pre_en, pre_pairs}, {tol != 0,
          (tol >= 4'h8 && tol <= 4'hc) ? 4'hc - tol : 4'h0});
    check({pre_cnt, pre_bits}, {exp_reg[7], exp_reg[7], 3'h0});
    check(bip, exp_reg[6][6]);
    check(ccrc, exp_reg[6][5]);
    check(whit, exp_reg[6][3]);
    check(poly, {exp_reg[9], exp_reg[8]});
  endtask

  task automatic wr_reg(input int i, input logic [7:0] v);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, addr_of(i), v, 4'hf, rd, err);
    check(err, 0);
    exp_reg[i] = v;
    repeat (2) @(posedge i_mclk);
    #1;
    check_outputs();
  endtask

  task automatic rd_reg(input int i);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, addr_of(i), 8'h00, 4'h0, rd, err);
    check(rd, {24'h0, exp_reg[i]});
  endtask

  task automatic pulse_reset(input int n);
    @(posedge i_mclk);
    i_rst_n <= 1'b0;
    exp_reg = '{8'h00, 8'h08, 8'h37, 8'h00, 8'h00, 8'h0c, 8'h00,
                8'h00, 8'h00, 8'h00};
    repeat (n) @(posedge i_mclk);
    i_rst_n <= 1'b1;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] rd;
    logic        err;
    int          idx;
    i_rst_n = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    errors = 0;
    comparisons = 0;
    lfsr = 32'd91029;
    pulse_reset(10);
    for (int i = 0; i < 10; i++) rd_reg(i);
    #1;
    check_outputs();
    $display("test reset values done");
    // Every code of the bandwidth and modulation byte
    for (int v = 0; v < 256; v++) wr_reg(0, v[7:0]);
    wr_reg(0, 8'h00);
    $display("test modulation sweep done");
    // Each correction mode against every tolerance value
    for (int t = 0; t < 16; t++) begin
      wr_reg(5, t[7:0]);
      for (int m = 0; m < 4; m++) wr_reg(1, legal(1, m[7:0]));
    end
    $display("test correction modes done");
    for (int k = 0; k < 200; k++) begin
      lfsr = lfsr_next(lfsr);
      idx = int'(lfsr[3:0]) % 10;
      wr_reg(idx, legal(idx, lfsr[15:8]));
      if (lfsr[16]) rd_reg(idx);
    end
    for (int i = 0; i < 10; i++) rd_reg(i);
    $display("test random traffic done");
    // Missing byte strobe: write dropped without error
    apb(1'b1, addr_of(7), 8'h5a, 4'he, rd, err);
    check(err, 0);
    rd_reg(7);
    // Hole in the map and past its end
    apb(1'b1, 12'h468, 8'hff, 4'hf, rd, err);
    check(err, 1);
    apb(1'b0, 12'h468, 8'h00, 4'h0, rd, err);
    check(rd, 32'h0);
    check(err, 1);
    apb(1'b0, 12'h480, 8'h00, 4'h0, rd, err);
    check(err, 1);
    for (int i = 0; i < 10; i++) rd_reg(i);
    #1;
    check_outputs();
    $display("test refused accesses done");
    // Reset in mid-run brings every byte back
    pulse_reset(3);
    for (int i = 0; i < 10; i++) rd_reg(i);
    #1;
    check_outputs();
    $display("test mid-run reset done");
    tally_and_finish();
  end
endmodule // tb_top
